//--- include/occ_defines.vh
// console control constants: mode codes, switch codes, sequencer states, reset values
// assumes inclusion by bare name from the console control design file
`ifndef OCC_DEFINES_VH
`define OCC_DEFINES_VH
// mode select codes
`define OCC_MODE_SET_A 3'h0
`define OCC_MODE_SET_B 3'h1
`define OCC_MODE_SET_C 3'h2
`define OCC_MODE_PROG_RUN 3'h3
`define OCC_MODE_SET_P 3'h4
`define OCC_MODE_DISP_MEM 3'h5
`define OCC_MODE_INS_MEM 3'h6
// buzzer switch codes
`define OCC_BUZ_UP 2'h0
`define OCC_BUZ_CENTER 2'h1
`define OCC_BUZ_DOWN 2'h2
// insert switch position codes, two bits per switch
`define OCC_SW_CENTER 2'h0
// console sequencer states
`define OCC_ST_IDLE 3'h0
`define OCC_ST_STEP 3'h1
`define OCC_ST_WRITE 3'h2
`define OCC_ST_READ 3'h3
`define OCC_ST_CMP 3'h4
// reset values
`define OCC_WORD_RST 18'h00000
`define OCC_IDX_RST 7'h00
`define OCC_ADDR_RST 15'h0000
`endif

//--- rtl/occ_console.v
// operator console control: switches and buttons steer run/halt, register
// loading, memory display/insert with read-back compare and resets.
// assumes switch and button pins are asynchronous and bounce-free; memory
// drives read data while mem_rd stands, taken at the edge that ends it.
`timescale 1ns/1ns
`include "occ_defines.vh"

// Behaviour
// - while the location-counter count-inhibit switch is on the counter holds, except that display steps still advance it.
// - while the second-counter count-inhibit switch is on that counter holds.
// - with halt disable on every halt condition is ignored, else it halts.
// - program position forces run on and ignores both inhibits and halts.
// - in manual position any halt condition halts the processor unless halt disable is on.
// - buzzer switch up silences, center lets it sound, down prevents it.
// - an insert switch reads one when up or down and zero when centered.
// - manual load starts the bootstrap load only in program run mode.
// - run starts continuous operation only in program run, display or insert.
// - single cycle halts a running machine, then each press does one step.
// - master reset clears every register and counter; run is set to the program switch position.
// - register-set modes load the insert switches into the chosen register.
// - display shows the word at the location counter, a mismatch halts.
// - insert memory writes, reads back and on mismatch halts and buzzes.
// - each display step advances the location counter by one.
module occ_console #(
  parameter W = 18,
  parameter AW = 15,
  parameter CW = 7
) (
  input wire mclk,
  input wire rst,
  input wire [2*W-1:0] insert_sw,
  input wire [2:0] mode_sel,
  input wire [1:0] buzzer_sw,
  input wire program_sw,
  input wire inhibit_loc_sw,
  input wire inhibit_q_sw,
  input wire halt_dis_sw,
  input wire load_btn,
  input wire run_btn,
  input wire step_btn,
  input wire master_rst_btn,
  input wire rst_a_btn,
  input wire rst_b_btn,
  input wire rst_c_btn,
  input wire rst_loc_btn,
  input wire rst_m_btn,
  input wire rst_y_btn,
  input wire cpu_halt_req,
  input wire cpu_loc_step,
  input wire cpu_q_step,
  input wire [W-1:0] mem_rdata,
  output reg run_reg,
  output reg boot_start_reg,
  output reg instr_step_reg,
  output reg buzzer_reg,
  output reg [W-1:0] a_reg,
  output reg [W-1:0] b_reg,
  output reg [CW-1:0] c_reg,
  output reg [AW-1:0] loc_reg,
  output reg [AW-1:0] q_reg,
  output reg [W-1:0] m_reg,
  output reg [W-1:0] y_reg,
  output reg mem_rd_reg,
  output reg mem_wr_reg,
  output reg [W-1:0] mem_wdata_reg,
  output reg mismatch_reg,
  output reg clear_all_reg
);

  localparam NB = 11;

  // three-stage synchronisers for every asynchronous pin bit
  wire [NB-1:0] btn_raw;
  reg [NB-1:0] s1_reg;
  reg [NB-1:0] s2_reg;
  reg [NB-1:0] s3_reg;
  reg [NB-1:0] btn_lvl_reg;
  wire [NB-1:0] press;
  reg [2*W-1:0] sw1_reg;
  reg [2*W-1:0] sw2_reg;
  reg [2*W-1:0] sw3_reg;
  reg [2*W-1:0] sw_lvl_reg;
  reg [8:0] lv1_reg;
  reg [8:0] lv2_reg;
  reg [8:0] lv3_reg;
  reg [8:0] lv_reg;
  wire [8:0] lv_raw;
  wire [2:0] mode;
  wire [1:0] buz;
  wire prog_pos;
  wire inh_loc;
  wire inh_q;
  wire halt_dis;
  wire [W-1:0] ins_val;
  reg [2:0] st_reg;
  reg [2:0] st_next;
  reg buz_latch_reg;
  reg loc_adv;
  wire halt_now;
  wire step_ok;
  genvar gi;

  assign btn_raw = {rst_y_btn, rst_m_btn, rst_loc_btn, rst_c_btn, rst_b_btn,
    rst_a_btn, master_rst_btn, step_btn, run_btn, load_btn, cpu_halt_req};
  assign lv_raw = {halt_dis_sw, inhibit_q_sw, inhibit_loc_sw, program_sw,
    buzzer_sw, mode_sel};

  // change accepted only when stages two and three agree
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_reg <= {NB{1'b0}};
      s2_reg <= {NB{1'b0}};
      s3_reg <= {NB{1'b0}};
      btn_lvl_reg <= {NB{1'b0}};
      sw1_reg <= {2*W{1'b0}};
      sw2_reg <= {2*W{1'b0}};
      sw3_reg <= {2*W{1'b0}};
      sw_lvl_reg <= {2*W{1'b0}};
      lv1_reg <= 9'h000;
      lv2_reg <= 9'h000;
      lv3_reg <= 9'h000;
      lv_reg <= 9'h000;
    end else begin
      s1_reg <= btn_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      btn_lvl_reg <= (s2_reg & s3_reg) | (btn_lvl_reg & (s2_reg | s3_reg));
      sw1_reg <= insert_sw;
      sw2_reg <= sw1_reg;
      sw3_reg <= sw2_reg;
      sw_lvl_reg <= (sw2_reg & sw3_reg) | (sw_lvl_reg & (sw2_reg | sw3_reg));
      lv1_reg <= lv_raw;
      lv2_reg <= lv1_reg;
      lv3_reg <= lv2_reg;
      lv_reg <= (lv2_reg & lv3_reg) | (lv_reg & (lv2_reg | lv3_reg));
    end
  end

  // a press is the rising edge of the filtered level, one cycle long;
  // bit 0 is the halt condition, used as a level and never as a press
  reg [NB-1:0] prev_lvl_reg;
  assign press = {btn_lvl_reg[NB-1:1] & ~prev_lvl_reg[NB-1:1], 1'b0};
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_lvl_reg <= {NB{1'b0}};
    end else begin
      prev_lvl_reg <= btn_lvl_reg;
    end
  end

  assign mode = lv_reg[2:0];
  assign buz = lv_reg[4:3];
  assign prog_pos = lv_reg[5];
  assign inh_loc = lv_reg[6] & ~prog_pos;
  assign inh_q = lv_reg[7] & ~prog_pos;
  assign halt_dis = lv_reg[8];

  // each insert switch is one when up or down, zero when centered
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_ins
      assign ins_val[gi] = (sw_lvl_reg[2*gi+1:2*gi] != `OCC_SW_CENTER);
    end
  endgenerate

  // program position masks halts; manual honours them unless disabled
  assign halt_now = (btn_lvl_reg[0] | mismatch_reg) & ~halt_dis
    & ~prog_pos;
  assign step_ok = press[3] & ~run_reg;

  // console memory sequencer
  always @* begin
    st_next = st_reg;
    case (st_reg)
      `OCC_ST_IDLE: begin
        if (step_ok && mode == `OCC_MODE_DISP_MEM) begin
          st_next = `OCC_ST_READ;
        end else if (step_ok && mode == `OCC_MODE_INS_MEM) begin
          st_next = `OCC_ST_WRITE;
        end
      end
      `OCC_ST_WRITE: st_next = `OCC_ST_READ;
      `OCC_ST_READ: st_next = `OCC_ST_CMP;
      `OCC_ST_CMP: st_next = `OCC_ST_IDLE;
      default: st_next = `OCC_ST_IDLE;
    endcase
  end

  always @* begin
    loc_adv = (st_reg == `OCC_ST_CMP) && (mode == `OCC_MODE_DISP_MEM);
  end

  // run control, console steps and registers
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= `OCC_ST_IDLE;
      run_reg <= 1'b0;
      boot_start_reg <= 1'b0;
      instr_step_reg <= 1'b0;
      buzzer_reg <= 1'b0;
      buz_latch_reg <= 1'b0;
      a_reg <= `OCC_WORD_RST;
      b_reg <= `OCC_WORD_RST;
      c_reg <= `OCC_IDX_RST;
      loc_reg <= `OCC_ADDR_RST;
      q_reg <= `OCC_ADDR_RST;
      m_reg <= `OCC_WORD_RST;
      y_reg <= `OCC_WORD_RST;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_wdata_reg <= `OCC_WORD_RST;
      mismatch_reg <= 1'b0;
      clear_all_reg <= 1'b0;
    end else if (press[4]) begin
      // master reset wipes console state in one cycle; run takes the program position
      st_reg <= `OCC_ST_IDLE;
      run_reg <= prog_pos;
      boot_start_reg <= 1'b0;
      instr_step_reg <= 1'b0;
      buzzer_reg <= 1'b0;
      buz_latch_reg <= 1'b0;
      a_reg <= `OCC_WORD_RST;
      b_reg <= `OCC_WORD_RST;
      c_reg <= `OCC_IDX_RST;
      loc_reg <= `OCC_ADDR_RST;
      q_reg <= `OCC_ADDR_RST;
      m_reg <= `OCC_WORD_RST;
      y_reg <= `OCC_WORD_RST;
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_wdata_reg <= `OCC_WORD_RST;
      mismatch_reg <= 1'b0;
      clear_all_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      clear_all_reg <= 1'b0;
      boot_start_reg <= press[1] && mode == `OCC_MODE_PROG_RUN;
      instr_step_reg <= step_ok && mode == `OCC_MODE_PROG_RUN;
      mem_wr_reg <= st_next == `OCC_ST_WRITE;
      mem_rd_reg <= st_next == `OCC_ST_READ;
      // run flip-flop: program lock, then step halt and halt conditions, then run
      if (prog_pos) begin
        run_reg <= 1'b1;
      end else if (press[3] || halt_now) begin
        run_reg <= 1'b0;
      end else if (press[2] && (mode == `OCC_MODE_PROG_RUN ||
          mode == `OCC_MODE_DISP_MEM || mode == `OCC_MODE_INS_MEM)) begin
        run_reg <= 1'b1;
      end
      // register-set modes take the insert value on a step press
      if (step_ok && mode == `OCC_MODE_SET_A) begin
        a_reg <= ins_val;
      end else if (press[5]) begin
        a_reg <= `OCC_WORD_RST;
      end
      if (step_ok && mode == `OCC_MODE_SET_B) begin
        b_reg <= ins_val;
      end else if (press[6]) begin
        b_reg <= `OCC_WORD_RST;
      end
      if (step_ok && mode == `OCC_MODE_SET_C) begin
        c_reg <= ins_val[CW-1:0];
      end else if (press[7]) begin
        c_reg <= `OCC_IDX_RST;
      end
      if (step_ok && mode == `OCC_MODE_SET_P) begin
        loc_reg <= ins_val[AW-1:0];
      end else if (press[8]) begin
        loc_reg <= `OCC_ADDR_RST;
      end else if (loc_adv || (cpu_loc_step && run_reg && !inh_loc)) begin
        loc_reg <= loc_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (cpu_q_step && run_reg && !inh_q) begin
        q_reg <= q_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (st_next == `OCC_ST_WRITE) begin
        mem_wdata_reg <= ins_val;
      end
      // read-back word lands in m, compare one cycle later
      if (st_reg == `OCC_ST_READ) begin
        m_reg <= mem_rdata;
      end else if (press[9]) begin
        m_reg <= `OCC_WORD_RST;
      end
      if (press[10]) begin
        y_reg <= `OCC_WORD_RST;
      end
      // mismatch holds until the next console step clears it
      if (st_reg == `OCC_ST_CMP && m_reg != ins_val) begin
        mismatch_reg <= 1'b1;
      end else if (step_ok) begin
        mismatch_reg <= 1'b0;
      end
      if (st_reg == `OCC_ST_CMP && m_reg != ins_val &&
          mode == `OCC_MODE_INS_MEM) begin
        buz_latch_reg <= 1'b1;
      end else if (buz == `OCC_BUZ_UP) begin
        buz_latch_reg <= 1'b0;
      end
      buzzer_reg <= buz_latch_reg && buz == `OCC_BUZ_CENTER;
    end
  end

endmodule

//--- dv/occ_console_checker.sv
// checker: timing relations at the console control ports
// bound into occ_console at its default widths; sees its ports only
`timescale 1ns/1ns
`include "occ_defines.vh"
module occ_console_checker (
  input wire mclk,
  input wire rst,
  input wire [2:0] mode_sel,
  input wire program_sw,
  input wire inhibit_q_sw,
  input wire halt_dis_sw,
  input wire cpu_halt_req,
  input wire cpu_q_step,
  input wire [17:0] mem_rdata,
  input wire run_reg,
  input wire boot_start_reg,
  input wire [17:0] a_reg,
  input wire [14:0] q_reg,
  input wire [17:0] m_reg,
  input wire mem_rd_reg,
  input wire mem_wr_reg,
  input wire clear_all_reg
);
  // switch levels cross a pin synchroniser, so they must hold 8 cycles first
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_q_hold;
    (inhibit_q_sw && !program_sw)[*8] |=> $stable(q_reg) || q_reg == 15'h0;
  endproperty
  a_q_hold: assert property (p_q_hold) else $error("q moved");
  property p_q_step;
    ((!inhibit_q_sw || program_sw)[*8] ##0
      cpu_q_step && run_reg && !clear_all_reg)
      |=> q_reg == $past(q_reg) + 15'h1;
  endproperty
  a_q_step: assert property (p_q_step) else $error("q not stepped");
  property p_prog_run;
    program_sw[*8] |-> run_reg;
  endproperty
  a_prog_run: assert property (p_prog_run) else $error("run not on");
  property p_halt;
    (cpu_halt_req && !halt_dis_sw && !program_sw)[*8] |-> !run_reg;
  endproperty
  a_halt: assert property (p_halt) else $error("halt ignored");
  property p_boot;
    boot_start_reg |-> mode_sel == `OCC_MODE_PROG_RUN;
  endproperty
  a_boot: assert property (p_boot) else $error("load in wrong mode");
  property p_wr_rd;
    mem_wr_reg |=> mem_rd_reg;
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("no read-back");
  property p_rd_m;
    mem_rd_reg |=> m_reg == $past(mem_rdata);
  endproperty
  a_rd_m: assert property (p_rd_m) else $error("word not shown");
  property p_clear;
    clear_all_reg |-> ##[0:1] (a_reg == 18'h0 && q_reg == 15'h0);
  endproperty
  a_clear: assert property (p_clear) else $error("not cleared");
endmodule
bind occ_console occ_console_checker u_chk (.mclk(mclk), .rst(rst),
  .mode_sel(mode_sel), .program_sw(program_sw), .inhibit_q_sw(inhibit_q_sw),
  .halt_dis_sw(halt_dis_sw), .cpu_halt_req(cpu_halt_req),
  .cpu_q_step(cpu_q_step), .mem_rdata(mem_rdata), .run_reg(run_reg),
  .boot_start_reg(boot_start_reg), .a_reg(a_reg), .q_reg(q_reg),
  .m_reg(m_reg), .mem_rd_reg(mem_rd_reg), .mem_wr_reg(mem_wr_reg),
  .clear_all_reg(clear_all_reg));

//--- dv/occ_mem_model.sv
// partner model: console memory, read word driven while mem_rd stands
// assumes the address is the location counter; flip spoils a read-back
`timescale 1ns/1ns
module occ_mem_model (
  input wire mclk,
  input wire mem_rd,
  input wire mem_wr,
  input wire [14:0] addr,
  input wire [17:0] wdata,
  input wire flip,
  output wire [17:0] rdata
);
  reg [17:0] mem [0:15];
  reg [17:0] junk;
  integer i;
  initial begin
    junk = 18'h2AAAA;
    for (i = 0; i < 16; i = i + 1) mem[i] = 18'h0;
  end
  // outside a read the bus toggles, so a stale word is never mistaken
  always @(posedge mclk) begin
    if (mem_wr) mem[addr[3:0]] <= wdata;
    junk <= ~junk;
  end
  assign rdata = mem_rd ? (mem[addr[3:0]] ^ {17'h0, flip}) : junk;
endmodule

//--- dv/occ_console_bench.sv
// testbench: console control driven as an operator at the panel
// memory partner answers reads; expectations come from switch folding
`timescale 1ns/1ns
`include "occ_defines.vh"
module occ_console_bench;
  reg mclk = 1'h0, rst = 1'h1, flip = 1'h0;
  reg [35:0] insert_sw = 36'h6C1B4E9D2;
  reg [2:0] mode_sel = `OCC_MODE_PROG_RUN;
  reg [1:0] buzzer_sw = `OCC_BUZ_CENTER;
  reg program_sw = 1'h0, inh_l = 1'h0, inh_q = 1'h0, halt_dis_sw = 1'h0;
  reg cpu_halt_req = 1'h0, lstep = 1'h0, qstep = 1'h0;
  reg [9:0] bt = 10'h000;
  wire run_reg, boot_start_reg, instr_step_reg, buzzer_reg, mem_rd_reg;
  wire mem_wr_reg, mismatch_reg, clear_all_reg;
  wire [17:0] a_reg, b_reg, m_reg, y_reg, mem_wdata_reg, mem_rdata, fv;
  wire [6:0] c_reg;
  wire [14:0] loc_reg, q_reg;
  integer error_cnt = 0, compares = 0, boots = 0, steps = 0, n;
  reg [17:0] wd;
  function [17:0] fold(input [35:0] s);
    integer k;
    for (k = 0; k < 18; k = k + 1) fold[k] = s[2*k +: 2] != `OCC_SW_CENTER;
  endfunction
  assign fv = fold(insert_sw);
  occ_console DUT (.mclk(mclk), .rst(rst), .insert_sw(insert_sw),
    .mode_sel(mode_sel), .buzzer_sw(buzzer_sw), .program_sw(program_sw),
    .inhibit_loc_sw(inh_l), .inhibit_q_sw(inh_q), .halt_dis_sw(halt_dis_sw),
    .load_btn(bt[0]), .run_btn(bt[1]), .step_btn(bt[2]),
    .master_rst_btn(bt[3]), .rst_a_btn(bt[4]), .rst_b_btn(bt[5]),
    .rst_c_btn(bt[6]), .rst_loc_btn(bt[7]), .rst_m_btn(bt[8]),
    .rst_y_btn(bt[9]), .cpu_halt_req(cpu_halt_req), .cpu_loc_step(lstep),
    .cpu_q_step(qstep), .mem_rdata(mem_rdata), .run_reg(run_reg),
    .boot_start_reg(boot_start_reg), .instr_step_reg(instr_step_reg),
    .buzzer_reg(buzzer_reg), .a_reg(a_reg), .b_reg(b_reg), .c_reg(c_reg),
    .loc_reg(loc_reg), .q_reg(q_reg), .m_reg(m_reg), .y_reg(y_reg),
    .mem_rd_reg(mem_rd_reg), .mem_wr_reg(mem_wr_reg),
    .mem_wdata_reg(mem_wdata_reg), .mismatch_reg(mismatch_reg),
    .clear_all_reg(clear_all_reg));
  occ_mem_model u_mem (.mclk(mclk), .mem_rd(mem_rd_reg), .mem_wr(mem_wr_reg),
    .addr(loc_reg), .wdata(mem_wdata_reg), .flip(flip), .rdata(mem_rdata));
  initial forever #20 mclk = ~mclk;
  // one-cycle pulses are counted here so no scenario can miss them
  always @(posedge mclk) begin
    if (boot_start_reg) boots <= boots + 1;
    if (instr_step_reg) steps <= steps + 1;
    if (mem_wr_reg) wd <= mem_wdata_reg;
  end
  task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    compares = compares + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(negedge mclk);
  endtask
  // press covers the pin filter latency and the gap between presses
  task press(input integer i);
    bt[i] = 1'h1;
    cyc(8);
    bt[i] = 1'h0;
    cyc(8);
  endtask
  task pulse;
    lstep = 1'h1;
    qstep = 1'h1;
    cyc(1);
    lstep = 1'h0;
    qstep = 1'h0;
    cyc(2);
  endtask
  task summarize;
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task s_load;
    mode_sel = `OCC_MODE_SET_A;
    press(2);
    mode_sel = `OCC_MODE_SET_B;
    press(2);
    mode_sel = `OCC_MODE_SET_C;
    press(2);
    mode_sel = `OCC_MODE_SET_P;
    press(2);
    chk("a", fv, a_reg);
    chk("b", fv, b_reg);
    chk("c", {11'h0, fv[6:0]}, {11'h0, c_reg});
    chk("loc", {3'h0, fv[14:0]}, {3'h0, loc_reg});
  endtask
  task s_rst1;
    mode_sel = `OCC_MODE_PROG_RUN;
    press(4);
    chk("a", 18'h0, a_reg);
    chk("b", fv, b_reg);
    press(6);
    chk("c", 18'h0, {11'h0, c_reg});
    press(7);
    chk("loc", 18'h0, {3'h0, loc_reg});
    press(9);
    chk("y", 18'h0, y_reg);
  endtask
  task s_ins;
    mode_sel = `OCC_MODE_INS_MEM;
    press(2);
    chk("wdata", fv, wd);
    chk("m", fv, m_reg);
    chk("mism", 18'h0, {17'h0, mismatch_reg});
    flip = 1'h1;
    press(2);
    flip = 1'h0;
    chk("mism", 18'h1, {17'h0, mismatch_reg});
    chk("buzz", 18'h1, {17'h0, buzzer_reg});
    buzzer_sw = `OCC_BUZ_DOWN;
    cyc(8);
    chk("buzz", 18'h0, {17'h0, buzzer_reg});
    buzzer_sw = `OCC_BUZ_CENTER;
    cyc(8);
    chk("buzz", 18'h1, {17'h0, buzzer_reg});
    buzzer_sw = `OCC_BUZ_UP;
    cyc(8);
    chk("buzz", 18'h0, {17'h0, buzzer_reg});
    buzzer_sw = `OCC_BUZ_CENTER;
    press(8);
    chk("m", 18'h0, m_reg);
    chk("buzz", 18'h0, {17'h0, buzzer_reg});
  endtask
  task s_disp;
    mode_sel = `OCC_MODE_DISP_MEM;
    press(2);
    chk("m", fv, m_reg);
    chk("mism", 18'h0, {17'h0, mismatch_reg});
    chk("loc", 18'h1, {3'h0, loc_reg});
    press(2);
    chk("mism", 18'h1, {17'h0, mismatch_reg});
    chk("loc", 18'h2, {3'h0, loc_reg});
  endtask
  task s_mast;
    mode_sel = `OCC_MODE_PROG_RUN;
    press(3);
    chk("b", 18'h0, b_reg);
    chk("loc", 18'h0, {3'h0, loc_reg});
    chk("mism", 18'h0, {17'h0, mismatch_reg});
  endtask
  task s_run;
    mode_sel = `OCC_MODE_SET_A;
    press(1);
    press(0);
    chk("run", 18'h0, {17'h0, run_reg});
    chk("boot", 18'h0, boots[17:0]);
    mode_sel = `OCC_MODE_PROG_RUN;
    press(0);
    chk("boot", 18'h1, boots[17:0]);
    press(1);
    chk("run", 18'h1, {17'h0, run_reg});
    halt_dis_sw = 1'h1;
    cpu_halt_req = 1'h1;
    cyc(10);
    chk("run", 18'h1, {17'h0, run_reg});
    halt_dis_sw = 1'h0;
    cyc(10);
    chk("run", 18'h0, {17'h0, run_reg});
    cpu_halt_req = 1'h0;
    press(1);
    n = steps;
    press(2);
    chk("run", 18'h0, {17'h0, run_reg});
    chk("steps", n[17:0], steps[17:0]);
    press(2);
    chk("steps", n[17:0] + 18'h1, steps[17:0]);
  endtask
  task s_cnt;
    press(1);
    inh_l = 1'h1;
    inh_q = 1'h1;
    cyc(8);
    pulse;
    chk("loc", 18'h0, {3'h0, loc_reg});
    chk("q", 18'h0, {3'h0, q_reg});
    inh_l = 1'h0;
    inh_q = 1'h0;
    cyc(8);
    pulse;
    chk("loc", 18'h1, {3'h0, loc_reg});
    chk("q", 18'h1, {3'h0, q_reg});
    inh_l = 1'h1;
    inh_q = 1'h1;
    program_sw = 1'h1;
    cyc(8);
    pulse;
    chk("loc", 18'h2, {3'h0, loc_reg});
    chk("q", 18'h2, {3'h0, q_reg});
    chk("run", 18'h1, {17'h0, run_reg});
  endtask
  initial begin
    cyc(3);
    rst = 1'h0;
    cyc(8);
    s_load;
    s_rst1;
    s_ins;
    s_disp;
    s_mast;
    s_run;
    s_cnt;
    summarize;
  end
  // a hang counts as a mismatch and ends the run
  initial begin
    cyc(20000);
    error_cnt = error_cnt + 1;
    summarize;
  end
endmodule
